// ===== rtl/gpio_pin_control.sv
// Eight-pin general purpose port with register access and pin sampling
`timescale 1ns/1ps
`include "gpio_params.svh"
module gpio_pin_control #(
  parameter int PINS   = `GPIO_PIN_COUNT,
  parameter int ADDR_W = `GPIO_ADDR_W
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // AXI4-Lite register port
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Sleep controller and external interrupt unit
  input  wire logic              sleep_clamp_i,
  input  wire logic [PINS-1:0]   ext_int_enable_i,
  // Pads
  input  wire logic [PINS-1:0]   pad_in_i,
  output logic      [PINS-1:0]   pad_out_o,
  output logic      [PINS-1:0]   pad_oe_o,
  output logic      [PINS-1:0]   pullup_en_o,
  // Interrupt
  output logic                   irq_o
);
  logic [PINS-1:0] pin_output_bit;
  logic [PINS-1:0] pin_direction_bit;
  logic [PINS-1:0] pin_input_sample_bit;
  logic [PINS-1:0] sample_prev;
  logic [PINS-1:0] irq_status;
  logic [PINS-1:0] irq_enable;
  logic            global_pullup_kill;

  logic [PINS-1:0] next_output;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] digital_in;
  logic [PINS-1:0] pin_change;

  gpio_reg_if #(.ADDR_W(ADDR_W)) regs ();

  // Bus slave
  gpio_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .awaddr_i   (s_axi_awaddr_i),
    .awvalid_i  (s_axi_awvalid_i),
    .awready_o  (s_axi_awready_o),
    .wdata_i    (s_axi_wdata_i),
    .wstrb_i    (s_axi_wstrb_i),
    .wvalid_i   (s_axi_wvalid_i),
    .wready_o   (s_axi_wready_o),
    .bresp_o    (s_axi_bresp_o),
    .bvalid_o   (s_axi_bvalid_o),
    .bready_i   (s_axi_bready_i),
    .araddr_i   (s_axi_araddr_i),
    .arvalid_i  (s_axi_arvalid_i),
    .arready_o  (s_axi_arready_o),
    .rdata_o    (s_axi_rdata_o),
    .rresp_o    (s_axi_rresp_o),
    .rvalid_o   (s_axi_rvalid_o),
    .rready_i   (s_axi_rready_i),
    .regs       (regs)
  );

  // Write address decode; only the low byte lane carries register data
  wire lane0      = regs.wr_strb[0];
  wire wr_output  = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_OUTPUT);
  wire wr_dir     = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_DIRECTION);
  wire wr_sample  = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_SAMPLE);
  wire wr_control = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_CONTROL);
  wire wr_clear   = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_IRQ_CLEAR);
  wire wr_enable  = regs.wr_en && lane0 && (regs.wr_addr == `GPIO_OFS_IRQ_ENABLE);
  wire [PINS-1:0] wr_byte = regs.wr_data[PINS-1:0];

  // Any mapped offset answers OKAY, even with the low lane off
  assign regs.wr_hit = (regs.wr_addr == `GPIO_OFS_OUTPUT)
                    || (regs.wr_addr == `GPIO_OFS_DIRECTION)
                    || (regs.wr_addr == `GPIO_OFS_SAMPLE)
                    || (regs.wr_addr == `GPIO_OFS_CONTROL)
                    || (regs.wr_addr == `GPIO_OFS_IRQ_STATUS)
                    || (regs.wr_addr == `GPIO_OFS_IRQ_CLEAR)
                    || (regs.wr_addr == `GPIO_OFS_IRQ_ENABLE);

  // Output bits: plain write, or toggle through the sample address
  assign next_output = wr_output ? wr_byte
                     : wr_sample ? (pin_output_bit ^ wr_byte)
                     : pin_output_bit;

  // Port configuration registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_output_bit    <= {PINS{`GPIO_RST_BIT}};
      pin_direction_bit <= {PINS{`GPIO_RST_BIT}};
    end else begin
      pin_output_bit <= next_output;
      if (wr_dir) begin
        pin_direction_bit <= wr_byte;
      end
    end
  end

  // Control register and interrupt enables
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      global_pullup_kill <= `GPIO_RST_BIT;
      irq_enable         <= {PINS{`GPIO_RST_BIT}};
    end else begin
      if (wr_control) begin
        global_pullup_kill <= regs.wr_data[`GPIO_CTRL_KILL_BIT];
      end
      if (wr_enable) begin
        irq_enable <= wr_byte;
      end
    end
  end

  // Pad driver and pull-up per pin
  genvar n;
  generate
    for (n = 0; n < PINS; n++) begin : g_pin
      // Driver follows the direction bit, level the output bit
      assign pad_oe_o[n]    = pin_direction_bit[n];
      assign pad_out_o[n]   = pin_direction_bit[n] & pin_output_bit[n];
      // Pull-up only on inputs with output bit one and no global kill
      assign pullup_en_o[n] = ~pin_direction_bit[n] & pin_output_bit[n]
                            & ~global_pullup_kill;
      // A driven pin sees its own register value from the rising edge on
      assign pin_level[n]   = pin_direction_bit[n] ? pin_output_bit[n]
                                                   : pad_in_i[n];
      // Deep sleep clamp unless the pin serves an enabled external interrupt
      assign digital_in[n]  = pin_level[n]
                            & ~(sleep_clamp_i & ~ext_int_enable_i[n]);
    end
  endgenerate

  // Falling-edge and rising-edge register stage feeding the sample bits
  gpio_pin_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .level_i    (digital_in),
    .sample_o   (pin_input_sample_bit)
  );

  // Change of a sample bit is the pin event; clamp release on wake counts too
  assign pin_change = pin_input_sample_bit ^ sample_prev;

  // Sticky pin change flags; a new change wins over a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sample_prev <= {PINS{`GPIO_RST_BIT}};
      irq_status  <= {PINS{`GPIO_RST_BIT}};
    end else begin
      sample_prev <= pin_input_sample_bit;
      irq_status  <= (irq_status & ~(wr_clear ? wr_byte : {PINS{1'b0}}))
                   | pin_change;
    end
  end

  // Level interrupt while an enabled flag is set
  assign irq_o = |(irq_status & irq_enable);

  // Read decode; narrow registers sit in the low bits, upper bits zero
  wire rd_output  = (regs.rd_addr == `GPIO_OFS_OUTPUT);
  wire rd_dir     = (regs.rd_addr == `GPIO_OFS_DIRECTION);
  wire rd_sample  = (regs.rd_addr == `GPIO_OFS_SAMPLE);
  wire rd_control = (regs.rd_addr == `GPIO_OFS_CONTROL);
  wire rd_status  = (regs.rd_addr == `GPIO_OFS_IRQ_STATUS);
  wire rd_clear   = (regs.rd_addr == `GPIO_OFS_IRQ_CLEAR);
  wire rd_enable  = (regs.rd_addr == `GPIO_OFS_IRQ_ENABLE);

  assign regs.rd_hit = rd_output | rd_dir | rd_sample | rd_control
                     | rd_status | rd_clear | rd_enable;

  wire [PINS-1:0] rd_byte =
      ({PINS{rd_output}} & pin_output_bit)
    | ({PINS{rd_dir}}    & pin_direction_bit)
    | ({PINS{rd_sample}} & pin_input_sample_bit)
    | ({PINS{rd_status}} & irq_status)
    | ({PINS{rd_enable}} & irq_enable);

  // Clear register reads as zero
  assign regs.rd_data = {{(32-PINS){1'b0}}, rd_byte}
                      | {31'h0000_0000, rd_control & global_pullup_kill};
endmodule // gpio_pin_control

// ===== rtl/gpio_params.svh
// Register offsets, reset values and bus codes of the port pin block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define GPIO_PIN_COUNT      8
`define GPIO_ADDR_W         8
`define GPIO_OFS_OUTPUT     8'h00
`define GPIO_OFS_DIRECTION  8'h04
`define GPIO_OFS_SAMPLE     8'h08
`define GPIO_OFS_CONTROL    8'h0C
`define GPIO_OFS_IRQ_STATUS 8'h10
`define GPIO_OFS_IRQ_CLEAR  8'h14
`define GPIO_OFS_IRQ_ENABLE 8'h18
`define GPIO_CTRL_KILL_BIT  0
`define GPIO_RST_BYTE       8'h00
`define GPIO_RST_BIT        1'b0
`define GPIO_RST_WORD       32'h0000_0000
`define GPIO_RESP_OKAY      2'h0
`define GPIO_RESP_SLVERR    2'h2
`endif

// ===== rtl/gpio_pkg.sv
// Types shared by the port pin block
package gpio_pkg;
  typedef enum logic {
    W_IDLE,
    W_RESP
  } wr_state_t;
  typedef enum logic {
    R_IDLE,
    R_DATA
  } rd_state_t;
endpackage

// ===== rtl/gpio_reg_if.sv
// Register access carrier between the bus slave and the pin core
`timescale 1ns/1ps
interface gpio_reg_if #(
  parameter int ADDR_W = 8
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_hit;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport core (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

// ===== rtl/gpio_pin_sync.sv
// Falling-edge plus rising-edge register synchronizer for the pin levels
`timescale 1ns/1ps
module gpio_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] level_i,
  output logic      [WIDTH-1:0] sample_o
);
  logic [WIDTH-1:0] held;

  // Captures the level at each falling edge and holds it for a whole clock period
  always_ff @(negedge core_clk_i) begin
    if (sys_rst_i) begin
      held <= '0;
    end else begin
      held <= level_i;
    end
  end

  // Held value loads into the sample bits at the next rising edge
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sample_o <= '0;
    end else begin
      sample_o <= held;
    end
  end
endmodule // gpio_pin_sync

// ===== rtl/gpio_axil_slave.sv
// AXI4-Lite slave that turns bus cycles into register strobes
`timescale 1ns/1ps
`include "gpio_params.svh"
module gpio_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  gpio_reg_if.bus                regs
);
  gpio_pkg::wr_state_t wr_state;
  gpio_pkg::rd_state_t rd_state;
  wire wr_take;
  wire rd_take;

  // Address and data are taken together, one write at a time
  assign wr_take       = (wr_state == gpio_pkg::W_IDLE) && awvalid_i && wvalid_i;
  assign awready_o     = wr_take;
  assign wready_o      = wr_take;
  assign regs.wr_en    = wr_take;
  assign regs.wr_addr  = awaddr_i;
  assign regs.wr_data  = wdata_i;
  assign regs.wr_strb  = wstrb_i;
  assign rd_take       = (rd_state == gpio_pkg::R_IDLE) && arvalid_i;
  assign arready_o     = rd_take;
  assign regs.rd_addr  = araddr_i;

  // Write response one cycle after the take, held until accepted
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_state <= gpio_pkg::W_IDLE;
      bvalid_o <= 1'b0;
      bresp_o  <= `GPIO_RESP_OKAY;
    end else if (wr_take) begin
      wr_state <= gpio_pkg::W_RESP;
      bvalid_o <= 1'b1;
      bresp_o  <= regs.wr_hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
    end else if (bvalid_o && bready_i) begin
      wr_state <= gpio_pkg::W_IDLE;
      bvalid_o <= 1'b0;
    end
  end

  // Read data registered at the take, held until accepted
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_state <= gpio_pkg::R_IDLE;
      rvalid_o <= 1'b0;
      rdata_o  <= `GPIO_RST_WORD;
      rresp_o  <= `GPIO_RESP_OKAY;
    end else if (rd_take) begin
      rd_state <= gpio_pkg::R_DATA;
      rvalid_o <= 1'b1;
      rdata_o  <= regs.rd_hit ? regs.rd_data : `GPIO_RST_WORD;
      rresp_o  <= regs.rd_hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      rd_state <= gpio_pkg::R_IDLE;
      rvalid_o <= 1'b0;
    end
  end
endmodule // gpio_axil_slave

// ===== verification/gpio_pin_control_assertions.sv
// Port-level assertions for the port pin block
`timescale 1ns/1ps
module gpio_pin_control_checker #(
  parameter int PINS = 8
) (
  input wire logic            core_clk_i,
  input wire logic            sys_rst_i,
  input wire logic            s_axi_awvalid_i,
  input wire logic            s_axi_awready_o,
  input wire logic [1:0]      s_axi_bresp_o,
  input wire logic            s_axi_bvalid_o,
  input wire logic            s_axi_bready_i,
  input wire logic            s_axi_arvalid_i,
  input wire logic            s_axi_arready_o,
  input wire logic            s_axi_rvalid_o,
  input wire logic            s_axi_rready_i,
  input wire logic [PINS-1:0] pad_out_o,
  input wire logic [PINS-1:0] pad_oe_o,
  input wire logic [PINS-1:0] pullup_en_o,
  input wire logic            irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Pad controls
  AST_RESET_QUIET: assert property ($fell(sys_rst_i) |-> !pad_oe_o && !pad_out_o && !pullup_en_o && !irq_o)
    else $error("pads or irq active after reset");
  AST_NO_PULL_DRIVEN: assert property ((pad_oe_o & pullup_en_o) == '0)
    else $error("pull-up on a driven pin");
  AST_OUT_ONLY_DRIVEN: assert property ((pad_out_o & ~pad_oe_o) == '0)
    else $error("drive level on an undriven pin");
  AST_PADS_NEED_WRITE: assert property (!(s_axi_awvalid_i && s_axi_awready_o) |=>
    $stable(pad_oe_o) && $stable(pad_out_o) && $stable(pullup_en_o))
    else $error("pad controls changed without a write");

  // Register bus handshakes
  AST_WRITE_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o |=> s_axi_bvalid_o)
    else $error("no write response one cycle after take");
  AST_READ_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read data one cycle after take");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("read data dropped before taken");
  AST_W_REFUSED: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write taken while response pending");
  AST_R_REFUSED: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");

  // Main scenarios
  COV_IRQ: cover property ($rose(irq_o));
  COV_PULL: cover property (|pullup_en_o);
  COV_SLVERR: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule // gpio_pin_control_checker

bind gpio_pin_control gpio_pin_control_checker #(.PINS(PINS)) chk_u (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o), .irq_o(irq_o));

// ===== verification/pin_board_model.sv
// Board model of the eight pads: chip drivers, pull-ups and outside sources
`timescale 1ns/1ps
module pin_board_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] drive_level_i,
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] pullup_en_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_level_i,
  output logic      [7:0] pad_level_o
);
  logic [7:0] last;

  // Chip driver wins, then outside source, then pull-up; a floating pad flips
  assign pad_level_o = (drive_en_i & drive_level_i) | (~drive_en_i & ext_en_i & ext_level_i)
                     | (~drive_en_i & ~ext_en_i & (pullup_en_i | ~last));

  // Last level, so a released pad with no pull-up and no outside source never keeps it
  always_ff @(posedge core_clk_i) last <= pad_level_o;
endmodule // pin_board_model

// ===== verification/gpio_pin_control_tb.sv
// Self-checking bench for the port pin block
`timescale 1ns/1ps
`include "gpio_params.svh"
module gpio_pin_control_tb;
  logic        core_clk, sys_rst, clamp, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, eint, pad_in, pad_out, pad_oe, pull_en, ext_en, ext_lvl;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, comparisons, k;

  gpio_pin_control dut_u (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_clamp_i(clamp),
    .ext_int_enable_i(eint), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .pullup_en_o(pull_en), .irq_o(irq));

  pin_board_model board_u (
    .core_clk_i(core_clk), .drive_level_i(pad_out), .drive_en_i(pad_oe), .pullup_en_i(pull_en),
    .ext_en_i(ext_en), .ext_level_i(ext_lvl), .pad_level_o(pad_in));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write with a one-cycle stall on the response channel
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge core_clk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge core_clk);
    bready <= 1'b1;
    do @(posedge core_clk); while (bvalid !== 1'b1 && ++n < 100);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // A handshake that never came is a mismatch, not a silent pass
    chk("write handshake", 32'h1, {31'h0, (n < 100)});
  endtask

  // Read with a one-cycle stall on the data channel
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er, input string what);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1 && ++n < 50);
    arvalid <= 1'b0;
    @(posedge core_clk);
    rready <= 1'b1;
    do @(posedge core_clk); while (rvalid !== 1'b1 && ++n < 100);
    rready <= 1'b0;
    chk(what, {24'h0, exp}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("read handshake", 32'h1, {31'h0, (n < 100)});
  endtask

  task automatic pads(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
    chk("pad_oe", {24'h0, oe}, {24'h0, pad_oe});
    chk("pad_out", {24'h0, o}, {24'h0, pad_out});
    chk("pullup_en", {24'h0, pu}, {24'h0, pull_en});
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, clamp} = '0;
    {awaddr, araddr, eint, ext_lvl, wdata} = '0;
    ext_en = 8'hFF;
    wstrb = 4'hF;
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    pads(8'h00, 8'h00, 8'h00);
    rd(`GPIO_OFS_OUTPUT, 8'h00, `GPIO_RESP_OKAY, "output");
    rd(`GPIO_OFS_DIRECTION, 8'h00, `GPIO_RESP_OKAY, "direction");
    ext_en <= 8'h88;
    ext_lvl <= 8'h80;
    // Output before direction, so on the first pass a pin set high steps through pull-up, never drive low
    for (k = 0; k < 2; k++) begin
      wr(`GPIO_OFS_CONTROL, k[7:0], `GPIO_RESP_OKAY);
      wr(`GPIO_OFS_OUTPUT, 8'h55, `GPIO_RESP_OKAY);
      wr(`GPIO_OFS_DIRECTION, 8'h33, `GPIO_RESP_OKAY);
      pads(8'h33, 8'h11, (k == 0) ? 8'h44 : 8'h00);
      rd(`GPIO_OFS_CONTROL, k[7:0], `GPIO_RESP_OKAY, "kill bit");
      if (k == 0) rd(`GPIO_OFS_SAMPLE, 8'hD5, `GPIO_RESP_OKAY, "sample");
    end
    wr(`GPIO_OFS_CONTROL, 8'h00, `GPIO_RESP_OKAY);
    wr(`GPIO_OFS_SAMPLE, 8'h81, `GPIO_RESP_OKAY);
    rd(`GPIO_OFS_OUTPUT, 8'hD4, `GPIO_RESP_OKAY, "toggled output");
    pads(8'h33, 8'h10, 8'hC4);
    // Masked, enabled and cleared pin change event
    wr(`GPIO_OFS_IRQ_CLEAR, 8'hFF, `GPIO_RESP_OKAY);
    rd(`GPIO_OFS_IRQ_STATUS, 8'h00, `GPIO_RESP_OKAY, "status cleared");
    rd(`GPIO_OFS_IRQ_CLEAR, 8'h00, `GPIO_RESP_OKAY, "clear reads");
    ext_lvl <= 8'h88;
    repeat (3) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`GPIO_OFS_IRQ_STATUS, 8'h08, `GPIO_RESP_OKAY, "status");
    wr(`GPIO_OFS_IRQ_ENABLE, 8'h08, `GPIO_RESP_OKAY);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(`GPIO_OFS_IRQ_CLEAR, 8'h08, `GPIO_RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(8'h1C, 8'hFF, `GPIO_RESP_SLVERR);
    rd(8'h1C, 8'h00, `GPIO_RESP_SLVERR, "unmapped");
    // Low byte lane off: answered OKAY, register untouched
    wstrb <= 4'hE;
    wr(`GPIO_OFS_OUTPUT, 8'h00, `GPIO_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`GPIO_OFS_OUTPUT, 8'hD4, `GPIO_RESP_OKAY, "lane off output");
    // Deep sleep clamp with two pins kept as interrupt inputs
    clamp <= 1'b1;
    eint <= 8'h0C;
    // Let the clamped levels pass the falling-edge and rising-edge register stage first
    repeat (2) @(posedge core_clk);
    rd(`GPIO_OFS_SAMPLE, 8'h0C, `GPIO_RESP_OKAY, "clamped sample");
    wr(`GPIO_OFS_IRQ_CLEAR, 8'hFF, `GPIO_RESP_OKAY);
    rd(`GPIO_OFS_IRQ_STATUS, 8'h00, `GPIO_RESP_OKAY, "status asleep");
    clamp <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(`GPIO_OFS_IRQ_STATUS, 8'hD0, `GPIO_RESP_OKAY, "status on wake");
    wrap_up();
  end
endmodule // gpio_pin_control_tb
